// >>> dv/tb_top.sv
// self-checking bench of the clock gear controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------
  // signals
  // ------------------------------------------
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [9:0]  wb_adr_i = 10'h000;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic        hi_i     = 1'b0;
  logic        lo_i     = 1'b0;
  logic        halt_i   = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, hi_en, lo_en, sys, gdc, pre, pin, pin_oe, mon, sys_d;
  logic [7:0]  taps;
  logic [2:0]  msel     = 3'h0;
  int          n_errors = 0;
  int          n_checks = 0;
  int          hc       = 0;
  int          lc       = 0;
  int          ph       = 0;
  int          glitches = 0;

  ckg_top #(
    .WARM_CYC_00(19'h00010),
    .WARM_CYC_01(19'h00004),
    .WARM_CYC_10(19'h00008),
    .WARM_CYC_11(19'h0000C)
  ) uut (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .wb_cyc_i             (wb_cyc_i),
    .wb_stb_i             (wb_stb_i),
    .wb_we_i              (wb_we_i),
    .wb_adr_i             (wb_adr_i),
    .wb_dat_i             (wb_dat_i),
    .wb_sel_i             (wb_sel_i),
    .wb_dat_o             (wb_dat_o),
    .wb_ack_o             (wb_ack_o),
    .high_osc_i           (hi_i),
    .low_osc_i            (lo_i),
    .halt_i               (halt_i),
    .high_osc_enable_o    (hi_en),
    .low_osc_enable_o     (lo_en),
    .system_clock_o       (sys),
    .gear_domain_clock_o  (gdc),
    .prescaler_clock_o    (pre),
    .prescaler_taps_o     (taps),
    .clock_output_pin_o   (pin),
    .clock_output_pin_oe_o(pin_oe)
  );

  // ------------------------------------------
  // clock, oscillators, monitors
  // ------------------------------------------
  always #5 clk_i = ~clk_i;

  // oscillators only run while enabled, so a warm-up on the wrong one never ends right
  always @(posedge clk_i)
  begin
    hc <= (hc == 3) ? 0 : hc + 1;
    lc <= (lc == 5) ? 0 : lc + 1;
    if (hc == 3 && hi_en === 1'b1) hi_i <= ~hi_i;
    if (lc == 5 && lo_en === 1'b1) lo_i <= ~lo_i;
  end

  // any system clock phase shorter than 4 cycles counts as a runt pulse
  always @(posedge clk_i)
  begin
    sys_d <= sys;
    ph <= (sys !== sys_d) ? 0 : ph + 1;
    if (sys !== sys_d && ph < 3 && !rst_i) glitches <= glitches + 1;
  end

  always_comb
  begin
    case (msel)
      3'h0:    mon = sys;
      3'h1:    mon = gdc;
      3'h2:    mon = pre;
      3'h3:    mon = taps[0];
      default: mon = pin;
    endcase
  end

  // ------------------------------------------
  // tasks
  // ------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic conclude();
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic xfer(input logic [7:0] idx, input logic we, input logic [7:0] d,
                      output logic [31:0] q);
    int t;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h000000, d};
    wb_sel_i <= 4'h1;
    t = 0;
    do
    begin
      @(posedge clk_i);
      t++;
    end
    while (wb_ack_o !== 1'b1 && t < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (t >= 20) chk(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    xfer(idx, 1'b1, d, q);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    xfer(idx, 1'b0, 8'h00, q);
    chk(q, exp);
  endtask

  // period in clk cycles of the chosen clock, after two edges to settle
  task automatic per(input logic [2:0] s, input int exp);
    int   n;
    int   r;
    logic pv;
    msel = s;
    n = 0;
    r = 0;
    pv = 1'b1;
    repeat (4000)
    begin
      @(posedge clk_i);
      #1;
      if (r == 2) n++;
      if (mon === 1'b1 && pv === 1'b0) r++;
      pv = mon;
      if (r == 3) break;
    end
    chk(32'(n), 32'(exp));
  endtask

  function automatic int gper(input logic [2:0] g);
    return 8 << ((g > 3'h4) ? 4 : int'(g));
  endfunction

  // warm-up on the oscillator of period op cycles, polled until it ends
  task automatic warm(input logic [1:0] c, input logic [7:0] e0, input int op);
    logic [31:0] q;
    int          len;
    int          t0;
    int          dur;
    len = (c == 2'h0) ? 16 : 4 * int'(c);
    wr(8'hE2, {2'h0, c, 4'hC});
    wr(8'hE0, e0);
    wr(8'hE0, e0 | 8'h04);
    t0 = int'($time / 10);
    xfer(8'hE0, 1'b0, 8'h00, q);
    chk(32'(q[2]), 32'h1);
    while (q[2] === 1'b1 && int'($time / 10) - t0 < 2000)
      xfer(8'hE0, 1'b0, 8'h00, q);
    dur = int'($time / 10) - t0;
    chk(32'(dur >= (len - 1) * op && dur <= (len + 1) * op + 40), 32'h1);
  endtask

  // ------------------------------------------
  // sequence
  // ------------------------------------------
  initial
  begin
    logic [7:0] d;
    logic       acc;
    void'($urandom(32'hA45DC259));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'({hi_en, lo_en}), 32'h2);
    rdc(8'hE0, 32'hA0);
    rdc(8'hE1, 32'h0);
    rdc(8'hE2, 32'h2C);
    rdc(8'hE3, 32'h23);
    rdc(8'hE4, 32'h0);
    rdc(8'h40, 32'h0);
    per(3'h0, 16);
    repeat (6)
    begin
      d = 8'($urandom());
      wr(8'hE1, d & 8'hF7);
      rdc(8'hE1, 32'(d & 8'h07));
      wr(8'hE5, d);
      rdc(8'hE5, 32'(d & 8'h03));
    end
    for (int g = 0; g < 8; g++)
    begin
      wr(8'h40, 8'h00);
      wr(8'hE1, 8'(g));
      per(3'h1, gper(3'(g)));
      per(3'h0, 2 * gper(3'(g)));
    end
    wr(8'hE1, 8'h00);
    per(3'h2, 16);
    per(3'h3, 32);
    wr(8'hE0, 8'hA2);
    per(3'h2, 512);
    wr(8'hE4, 8'h55);
    rdc(8'hE3, 32'hA3);
    wr(8'hE1, 8'h02);
    rdc(8'hE1, 32'h0);
    wr(8'hE0, 8'hE0);
    chk(32'(lo_en), 32'h0);
    wr(8'hE4, 8'h1F);
    rdc(8'hE3, 32'h23);
    wr(8'hE0, 8'hA0);
    for (int c = 0; c < 4; c++) warm(2'(c), 8'hE0, 12);
    chk(32'({hi_en, lo_en}), 32'h3);
    wr(8'hE1, 8'h0B);
    // the new source is taken only at the end of a system clock period
    repeat (40) @(posedge clk_i);
    wr(8'hE0, 8'h60);
    chk(32'({hi_en, lo_en}), 32'h1);
    per(3'h1, 12);
    per(3'h0, 24);
    warm(2'h2, 8'hE0, 8);
    wr(8'hE1, 8'h00);
    per(3'h0, 16);
    wr(8'hE5, 8'h03);
    wr(8'hE2, 8'h08);
    halt_i <= 1'b1;
    per(3'h4, 12);
    chk(32'(pin_oe), 32'h1);
    wr(8'hE2, 8'h4C);
    per(3'h4, 16);
    wr(8'hE2, 8'h48);
    repeat (4) @(posedge clk_i);
    acc = 1'b0;
    repeat (40)
    begin
      @(posedge clk_i);
      acc = acc | pin;
    end
    chk(32'(acc), 32'h0);
    halt_i <= 1'b0;
    per(3'h4, 16);
    for (int k = 1; k < 3; k++)
    begin
      wr(8'hE5, 8'(k));
      repeat (3) @(posedge clk_i);
      chk(32'({pin_oe, pin}), 32'h0);
    end
    chk(32'(glitches), 32'h0);
    conclude();
  end

  // the whole sequence needs well under 40000 cycles
  initial
  begin
    repeat (80000) @(posedge clk_i);
    n_errors++;
    conclude();
  end
endmodule

// >>> hdl/ckg_link_if.sv
// links between the clock gear core, its bus port and its warm-up timer
interface ckg_link_if;
  logic       wr;
  logic [7:0] idx;
  logic [7:0] wdat;
  logic [7:0] rdat;
  logic       wu_start;
  logic [1:0] wu_len;
  logic       wu_edge;
  logic       wu_busy;
  modport bus  (output wr, idx, wdat, input rdat);
  modport core (input wr, idx, wdat, wu_busy, output rdat, wu_start, wu_len, wu_edge);
  modport warm (input wu_start, wu_len, wu_edge, output wu_busy);
endinterface

// >>> hdl/ckg_pkg.sv
// types and helper functions of the clock gear controller
package ckg_pkg;
  typedef enum logic [1:0] {
    CKG_WU_IDLE = 2'h0,
    CKG_WU_RUN  = 2'h1,
    CKG_WU_DONE = 2'h3
  } ckg_wu_state_type;

  typedef struct packed {
    ckg_wu_state_type state;
    logic [18:0]      cnt;
    logic [18:0]      len;
  } ckg_wu_type;

  typedef struct packed {
    logic       ack;
    logic [7:0] dat;
  } ckg_wb_type;

  typedef struct packed {
    logic       hi_s1, hi_s2, hi_s3, lo_s1, lo_s2, lo_s3;
    logic       hi_en, lo_en, pre_sel;
    logic [2:0] stop_cfg;
    logic       src_sel, act_sel;
    logic [2:0] gear, act_gear;
    logic [3:0] gear_cnt;
    logic       fph, sclk;
    logic [5:0] slow_cnt;
    logic       phi;
    logic [7:0] pre_div;
    logic       scosel, drve;
    logic [1:0] wu_sel, haltm;
    logic [6:0] emc;
    logic       prot, pin_dir, pin_fn, pin_val, pin_oe;
  } ckg_core_type;

  // half-period events of the high clock per gear-domain half period, minus one
  function automatic logic [3:0] ckg_gear_last(input logic [2:0] g);
    case (g)
      3'h0:    ckg_gear_last = 4'h0;
      3'h1:    ckg_gear_last = 4'h1;
      3'h2:    ckg_gear_last = 4'h3;
      3'h3:    ckg_gear_last = 4'h7;
      default: ckg_gear_last = 4'hF;
    endcase
  endfunction

  function automatic logic ckg_rise(input logic now_v, input logic old_v);
    ckg_rise = now_v & ~old_v;
  endfunction
endpackage

// >>> hdl/ckg_regs.svh
// register indices, field positions, reset values and counts of the clock gear controller
`ifndef CKG_REGS_SVH
`define CKG_REGS_SVH
// register indices; byte address is index times four
`define CKG_IDX_OSC      8'hE0
`define CKG_IDX_SRC      8'hE1
`define CKG_IDX_WUP      8'hE2
`define CKG_IDX_PRS      8'hE3
`define CKG_IDX_KEY      8'hE4
`define CKG_IDX_PIN      8'hE5
`define CKG_ADR_LSB      2
// field positions
`define CKG_OSC_HI_EN    7
`define CKG_OSC_LO_EN    6
`define CKG_OSC_STOP_HI  5
`define CKG_OSC_STOP_LO  3
`define CKG_OSC_WU       2
`define CKG_OSC_PRE      1
`define CKG_SRC_SEL      3
`define CKG_SRC_GEAR_HI  2
`define CKG_WUP_SCOSEL   6
`define CKG_WUP_LEN_HI   5
`define CKG_WUP_LEN_LO   4
`define CKG_WUP_HALT_HI  3
`define CKG_WUP_HALT_LO  2
`define CKG_WUP_DRVE     0
`define CKG_PRS_FLAG     7
`define CKG_PIN_DIR      0
`define CKG_PIN_FN       1
// reset values
`define CKG_RST_HI_EN    1'b1
`define CKG_RST_LO_EN    1'b0
`define CKG_RST_STOP     3'h4
`define CKG_RST_SEL      1'b0
`define CKG_RST_GEAR     3'h0
`define CKG_RST_WULEN    2'h2
`define CKG_RST_HALT     2'h3
`define CKG_RST_PRS      7'h23
`define CKG_KEY_OPEN     8'h1F
`define CKG_HALT_LIGHT   2'h3
// counts, in edges of the oscillator that is counted
`define CKG_WARM_08      19'h00100
`define CKG_WARM_14      19'h04000
`define CKG_WARM_16      19'h10000
`define CKG_WARM_18      19'h40000
`define CKG_SLOW_LAST    6'h3F
`endif

// >>> hdl/ckg_top.sv
// system clock gear controller: source select, gear, prescaler, clock pin, protection
//
// Behaviour
// RQ1: system clock comes from high or low oscillator per source select bit.
// RQ2: each oscillator has its own independent enable bit.
// RQ3: gear divides the high clock by 1, 2, 4, 8 or 16.
// RQ4: reset: high on, low off, high selected, gear zero; system clock is half.
// RQ5: gear applies only while the high clock is selected.
// RQ6: warm-up length select gives 2^8, 2^14, 2^16 or 2^18 oscillator cycles.
// RQ7: warm-up counter counts edges of the oscillator being started.
// RQ8: writing one starts warm-up; bit reads one while counting, zero when done.
// RQ9: software sequence for high to low switch, warm-up polled before select.
// RQ10: software sequence for low to high switch, warm-up polled before select.
// RQ11: new gear takes effect after a switching delay; software adds dummy write.
// RQ12: clock pin drives only when both its direction and function bits are one.
// RQ13: pin gives low clock always, or system clock except deep halt modes.
// RQ14: prescaler input is gear clock over 2 or high clock over 64.
// RQ15: prescaler supplies divided clocks to timers and serial units.
// RQ16: while protected, writes to clock registers are ignored.
// RQ17: key unlock value releases protection, other values engage it; flag readable.
// RQ18: source and gear changes never produce truncated system clock pulses.
`include "ckg_regs.svh"
module ckg_top #(
  parameter logic [18:0] WARM_CYC_00 = `CKG_WARM_18,
  parameter logic [18:0] WARM_CYC_01 = `CKG_WARM_08,
  parameter logic [18:0] WARM_CYC_10 = `CKG_WARM_14,
  parameter logic [18:0] WARM_CYC_11 = `CKG_WARM_16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        high_osc_i,
  input  wire logic        low_osc_i,
  input  wire logic        halt_i,
  output logic             high_osc_enable_o,
  output logic             low_osc_enable_o,
  output logic             system_clock_o,
  output logic             gear_domain_clock_o,
  output logic             prescaler_clock_o,
  output logic      [7:0]  prescaler_taps_o,
  output logic             clock_output_pin_o,
  output logic             clock_output_pin_oe_o
);
  ckg_link_if lk ();

  ckg_pkg::ckg_core_type st_reg;
  ckg_pkg::ckg_core_type st_next;
  logic                  hi_ev;
  logic                  lo_ev;
  logic                  fph_tog;
  logic                  slow_tog;
  logic                  phi_tog;
  logic                  run_view;

  ckg_wb_port u_bus (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_i (wb_dat_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .lk       (lk.bus)
  );

  ckg_warmup #(
    .CYC_00 (WARM_CYC_00),
    .CYC_01 (WARM_CYC_01),
    .CYC_10 (WARM_CYC_10),
    .CYC_11 (WARM_CYC_11)
  ) u_warm (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .lk    (lk.warm)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    // oscillator pins are asynchronous: two stages, third for edges
    st_next.hi_s1 = high_osc_i;
    st_next.hi_s2 = st_reg.hi_s1;
    st_next.hi_s3 = st_reg.hi_s2;
    st_next.lo_s1 = low_osc_i;
    st_next.lo_s2 = st_reg.lo_s1;
    st_next.lo_s3 = st_reg.lo_s2;
    // a disabled oscillator yields no edges at all
    hi_ev = st_reg.hi_en & (st_reg.hi_s2 ^ st_reg.hi_s3); // RQ2
    lo_ev = st_reg.lo_en & (st_reg.lo_s2 ^ st_reg.lo_s3); // RQ2

    // gear divider, active only on the high source
    fph_tog = 1'b0;
    if (!st_reg.act_sel) // RQ5
    begin
      if (hi_ev)
      begin
        if (st_reg.gear_cnt == ckg_pkg::ckg_gear_last(st_reg.act_gear)) // RQ3
        begin
          st_next.gear_cnt = 4'h0;
          fph_tog          = 1'b1;
        end
        else
          st_next.gear_cnt = st_reg.gear_cnt + 4'h1;
      end
    end
    else
      fph_tog = lo_ev; // RQ1

    // system clock is half the gear domain; new source and gear are taken
    // only at the end of a full system clock period, so no runt pulse
    if (fph_tog)
    begin
      st_next.fph = ~st_reg.fph;
      if (!st_reg.fph)
      begin
        st_next.sclk = ~st_reg.sclk; // RQ4
        if (st_reg.sclk)
        begin
          st_next.act_sel  = st_reg.src_sel; // RQ1
          st_next.act_gear = st_reg.gear; // RQ11
          st_next.gear_cnt = 4'h0; // RQ18
        end
      end
    end

    // ----------------------------------------------------------------
    // prescaler input and divider chain
    // ----------------------------------------------------------------
    slow_tog = 1'b0;
    if (hi_ev)
    begin
      if (st_reg.slow_cnt == `CKG_SLOW_LAST)
      begin
        st_next.slow_cnt = 6'h00;
        slow_tog         = 1'b1;
      end
      else
        st_next.slow_cnt = st_reg.slow_cnt + 6'h01;
    end
    // source switch is not synchronised to either clock; timers tolerate it
    phi_tog = st_reg.pre_sel ? slow_tog : (fph_tog & ~st_reg.fph); // RQ14
    if (phi_tog)
    begin
      st_next.phi = ~st_reg.phi;
      if (!st_reg.phi)
        st_next.pre_div = st_reg.pre_div + 8'h01; // RQ15
    end

    // ----------------------------------------------------------------
    // warm-up link
    // ----------------------------------------------------------------
    lk.wu_len   = st_reg.wu_sel;
    lk.wu_start = 1'b0;
    // the oscillator being started is the one not currently selected
    if (st_reg.src_sel) // RQ7
      lk.wu_edge = st_reg.hi_en & ckg_pkg::ckg_rise(st_reg.hi_s2, st_reg.hi_s3);
    else
      lk.wu_edge = st_reg.lo_en & ckg_pkg::ckg_rise(st_reg.lo_s2, st_reg.lo_s3);

    // ----------------------------------------------------------------
    // register read and write
    // ----------------------------------------------------------------
    case (lk.idx)
      `CKG_IDX_OSC: lk.rdat = {st_reg.hi_en, st_reg.lo_en, st_reg.stop_cfg,
                               lk.wu_busy, st_reg.pre_sel, 1'b0}; // RQ8
      `CKG_IDX_SRC: lk.rdat = {4'h0, st_reg.src_sel, st_reg.gear};
      `CKG_IDX_WUP: lk.rdat = {1'b0, st_reg.scosel, st_reg.wu_sel, st_reg.haltm,
                               1'b0, st_reg.drve};
      `CKG_IDX_PRS: lk.rdat = {st_reg.prot, st_reg.emc}; // RQ17
      `CKG_IDX_PIN: lk.rdat = {6'h00, st_reg.pin_fn, st_reg.pin_dir};
      default:      lk.rdat = 8'h00;
    endcase

    if (lk.wr)
    begin
      case (lk.idx)
        `CKG_IDX_OSC:
          if (!st_reg.prot) // RQ16
          begin
            st_next.hi_en    = lk.wdat[`CKG_OSC_HI_EN]; // RQ2
            st_next.lo_en    = lk.wdat[`CKG_OSC_LO_EN]; // RQ2
            st_next.stop_cfg = lk.wdat[`CKG_OSC_STOP_HI:`CKG_OSC_STOP_LO];
            st_next.pre_sel  = lk.wdat[`CKG_OSC_PRE];
            lk.wu_start      = lk.wdat[`CKG_OSC_WU]; // RQ8
          end
        `CKG_IDX_SRC:
          if (!st_reg.prot) // RQ16
          begin
            st_next.src_sel = lk.wdat[`CKG_SRC_SEL];
            st_next.gear    = lk.wdat[`CKG_SRC_GEAR_HI:0];
          end
        `CKG_IDX_WUP:
          if (!st_reg.prot) // RQ16
          begin
            st_next.scosel = lk.wdat[`CKG_WUP_SCOSEL];
            st_next.wu_sel = lk.wdat[`CKG_WUP_LEN_HI:`CKG_WUP_LEN_LO];
            st_next.haltm  = lk.wdat[`CKG_WUP_HALT_HI:`CKG_WUP_HALT_LO];
            st_next.drve   = lk.wdat[`CKG_WUP_DRVE];
          end
        `CKG_IDX_PRS: st_next.emc = lk.wdat[6:0];
        `CKG_IDX_KEY: st_next.prot = (lk.wdat != `CKG_KEY_OPEN); // RQ17
        `CKG_IDX_PIN:
        begin
          st_next.pin_dir = lk.wdat[`CKG_PIN_DIR];
          st_next.pin_fn  = lk.wdat[`CKG_PIN_FN];
        end
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // clock output pin
    // ----------------------------------------------------------------
    run_view = ~halt_i | (st_reg.haltm == `CKG_HALT_LIGHT);
    st_next.pin_oe = st_reg.pin_dir & st_reg.pin_fn; // RQ12
    if (!st_next.pin_oe)
      st_next.pin_val = 1'b0;
    else if (!st_reg.scosel)
      st_next.pin_val = st_reg.lo_s2; // RQ13
    else
      st_next.pin_val = run_view & st_reg.sclk; // RQ13
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg          <= '0;
      st_reg.hi_en    <= `CKG_RST_HI_EN; // RQ4
      st_reg.lo_en    <= `CKG_RST_LO_EN; // RQ4
      st_reg.stop_cfg <= `CKG_RST_STOP;
      st_reg.src_sel  <= `CKG_RST_SEL; // RQ4
      st_reg.act_sel  <= `CKG_RST_SEL;
      st_reg.gear     <= `CKG_RST_GEAR; // RQ4
      st_reg.act_gear <= `CKG_RST_GEAR;
      st_reg.wu_sel   <= `CKG_RST_WULEN;
      st_reg.haltm    <= `CKG_RST_HALT;
      st_reg.emc      <= `CKG_RST_PRS;
    end
    else
      st_reg <= st_next;
  end

  assign high_osc_enable_o     = st_reg.hi_en;
  assign low_osc_enable_o      = st_reg.lo_en;
  assign system_clock_o        = st_reg.sclk;
  assign gear_domain_clock_o   = st_reg.fph;
  assign prescaler_clock_o     = st_reg.phi;
  assign prescaler_taps_o      = st_reg.pre_div;
  assign clock_output_pin_o    = st_reg.pin_val;
  assign clock_output_pin_oe_o = st_reg.pin_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking core_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence key_write_s;
    lk.wr && lk.idx == `CKG_IDX_KEY;
  endsequence

  key_unlock_a: assert property ( // RQ17
    key_write_s |=> st_reg.prot == ($past(lk.wdat) != `CKG_KEY_OPEN))
    else $error("protection flag wrong after key write");

  protect_block_a: assert property ( // RQ16
    lk.wr && lk.idx == `CKG_IDX_SRC && st_reg.prot
      |=> $stable(st_reg.gear) && $stable(st_reg.src_sel))
    else $error("protected register was written");

  reset_cfg_a: assert property ( // RQ4
    $fell(rst_i) |-> st_reg.hi_en && !st_reg.lo_en && !st_reg.src_sel
      && st_reg.gear == 3'h0 && !st_reg.sclk)
    else $error("wrong configuration after reset");

  pin_enable_a: assert property ( // RQ12
    clock_output_pin_o |-> clock_output_pin_oe_o && $past(st_reg.pin_fn))
    else $error("clock pin driven while not enabled");

  pin_deep_a: assert property ( // RQ13
    st_reg.scosel && halt_i && st_reg.haltm != `CKG_HALT_LIGHT
      ##1 $stable(st_reg.scosel) |-> !clock_output_pin_o)
    else $error("clock pin toggles in deep halt");

  gear_apply_a: assert property ( // RQ11
    $changed(st_reg.act_gear) || $changed(st_reg.act_sel) |-> $fell(st_reg.sclk))
    else $error("clock change outside period boundary");

  no_runt_a: assert property ( // RQ18
    $rose(st_reg.sclk) |-> st_reg.sclk [*2])
    else $error("runt system clock pulse");

  source_gate_a: assert property ( // RQ1
    !st_reg.act_sel && !st_reg.hi_en |=> $stable(st_reg.fph))
    else $error("gear clock moved without high oscillator");

  osc_write_a: assert property ( // RQ2
    lk.wr && lk.idx == `CKG_IDX_OSC && !st_reg.prot
      |=> st_reg.hi_en == $past(lk.wdat[`CKG_OSC_HI_EN])
      && st_reg.lo_en == $past(lk.wdat[`CKG_OSC_LO_EN]))
    else $error("oscillator enable write lost");

  gear_count_a: assert property ( // RQ3
    !st_reg.act_sel && hi_ev
      && st_reg.gear_cnt != ckg_pkg::ckg_gear_last(st_reg.act_gear) |=> $stable(st_reg.fph))
    else $error("gear clock toggled before ratio count");

  low_edge_a: assert property ( // RQ5
    st_reg.act_sel && !lo_ev |=> $stable(st_reg.fph))
    else $error("gear clock moved without low oscillator edge");

  warm_source_a: assert property ( // RQ7
    lk.wu_edge |-> (st_reg.src_sel ? st_reg.hi_en : st_reg.lo_en))
    else $error("warm-up counted a stopped oscillator");

  prescale_fast_a: assert property ( // RQ14
    st_reg.pre_sel && !hi_ev |=> $stable(st_reg.phi))
    else $error("prescaler input moved without high edge");

  taps_step_a: assert property ( // RQ15
    $rose(st_reg.phi) |-> st_reg.pre_div == 8'($past(st_reg.pre_div) + 8'h01))
    else $error("prescaler taps did not advance");

  pin_oe_a: assert property ( // RQ12
    clock_output_pin_oe_o |-> $past(st_reg.pin_dir) && $past(st_reg.pin_fn))
    else $error("clock pin enabled without both bits");

  pin_low_a: assert property ( // RQ13
    st_reg.pin_dir && st_reg.pin_fn && !st_reg.scosel
      |=> clock_output_pin_o == $past(st_reg.lo_s2))
    else $error("clock pin does not follow low clock");
endmodule

// >>> hdl/ckg_warmup.sv
// warm-up timer counting edges of the oscillator being started
`include "ckg_regs.svh"
module ckg_warmup #(
  parameter logic [18:0] CYC_00 = `CKG_WARM_18,
  parameter logic [18:0] CYC_01 = `CKG_WARM_08,
  parameter logic [18:0] CYC_10 = `CKG_WARM_14,
  parameter logic [18:0] CYC_11 = `CKG_WARM_16
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  ckg_link_if.warm  lk
);
  ckg_pkg::ckg_wu_type st_reg;
  ckg_pkg::ckg_wu_type st_next;

  always_comb
  begin
    st_next = st_reg;
    case (st_reg.state)
      ckg_pkg::CKG_WU_RUN:
        if (lk.wu_edge)
        begin
          st_next.cnt = st_reg.cnt + 19'h00001;
          if (st_next.cnt == st_reg.len)
            st_next.state = ckg_pkg::CKG_WU_DONE;
        end
      ckg_pkg::CKG_WU_IDLE, ckg_pkg::CKG_WU_DONE: ;
      default: st_next.state = ckg_pkg::CKG_WU_IDLE;
    endcase
    // a start always clears and restarts, even mid-count
    if (lk.wu_start) // RQ8
    begin
      st_next.state = ckg_pkg::CKG_WU_RUN;
      st_next.cnt   = '0;
      case (lk.wu_len) // RQ6
        2'h1:    st_next.len = CYC_01;
        2'h2:    st_next.len = CYC_10;
        2'h3:    st_next.len = CYC_11;
        default: st_next.len = CYC_00;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign lk.wu_busy = (st_reg.state == ckg_pkg::CKG_WU_RUN); // RQ8

  default clocking wu_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence wu_start_s;
    lk.wu_start;
  endsequence

  warm_start_a: assert property ( // RQ8
    wu_start_s |=> lk.wu_busy && st_reg.cnt == 19'h00000)
    else $error("warm-up did not restart");

  warm_len_a: assert property ( // RQ6
    $fell(lk.wu_busy) && !$past(lk.wu_start) |-> st_reg.cnt == st_reg.len
      && $past(st_reg.cnt) == st_reg.len - 19'h00001)
    else $error("warm-up ended at wrong count");
endmodule

// >>> hdl/ckg_wb_port.sv
// classic wishbone slave port of the clock gear controller
`include "ckg_regs.svh"
module ckg_wb_port (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  ckg_link_if.bus          lk
);
  ckg_pkg::ckg_wb_type st_reg;
  ckg_pkg::ckg_wb_type st_next;
  logic                req;

  always_comb
  begin
    st_next  = st_reg;
    req      = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    lk.idx   = wb_adr_i[9:`CKG_ADR_LSB];
    lk.wdat  = wb_dat_i[7:0];
    // only the low lane carries register data
    lk.wr    = req & wb_we_i & wb_sel_i[0];
    st_next.ack = req;
    st_next.dat = (req & ~wb_we_i) ? lk.rdat : 8'h00;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = {24'h000000, st_reg.dat};
endmodule
